// File: logic/pcitr_pkg.sv
package pcitr_pkg;
   // register map of the axi4-lite slave (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_BAR0 = 8'h10;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b0;
   localparam logic [31:0] BAR_RST = 32'h0000_0000;
   // target status vector layout
   localparam int TSV_W = 12;
   localparam int TSV_WIDE = 7;
   localparam int TSV_BUSY = 8;
   localparam int TSV_BURST = 9;
   localparam int TSV_DONE = 10;
   // memory read commands that this target claims
   localparam logic [3:0] CMD_MEM_READ = 4'h6;
   localparam logic [3:0] CMD_READ_MULT = 4'hc;
   localparam logic [3:0] CMD_READ_LINE = 4'he;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_DECODE = 5'h02,
      ST_CLAIM = 5'h04,
      ST_DATA = 5'h08,
      ST_DONE = 5'h10
   } pcitr_state_t;
endpackage

// File: logic/pcitr_stream_if.sv
interface pcitr_stream_if #(parameter int W = 64);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface

// File: logic/pcitr_pair_buf.sv
module pcitr_pair_buf #(
   parameter int W = 64,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   pcitr_stream_if.snk inS,
   pcitr_stream_if.src outS,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH+1);
   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr_q, rdPtr_q;
   logic [CW-1:0] count_q;
   logic push, pop, bypass, store, take;

   // empty buffer passes the word straight through, so no cycle is lost
   assign bypass = (count_q == '0);
   assign inS.ready = (count_q < CW'(DEPTH));
   assign outS.valid = !bypass || inS.valid;
   assign outS.data = bypass ? inS.data : mem[rdPtr_q];
   assign push = inS.valid && inS.ready;
   assign pop = outS.valid && outS.ready;
   assign store = push && !(bypass && pop);
   assign take = pop && !bypass;
   assign level = count_q;

   // pointers and fill level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else if (flush) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (store) begin
            wrPtr_q <= (wrPtr_q == PW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
         end
         if (take) begin
            rdPtr_q <= (rdPtr_q == PW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
         end
         count_q <= count_q + CW'(store) - CW'(take);
      end
   end

   // storage needs no reset; valid comes from the count
   always_ff @(posedge clk) begin
      if (store) begin
         mem[wrPtr_q] <= inS.data;
      end
   end
endmodule

// File: logic/pcitr_bar_decode.sv
module pcitr_bar_decode #(
   parameter int NUM_BAR = 6,
   parameter int BAR_SIZE_BITS = 12
) (
   input wire logic [31:0] addr,
   input wire logic [31:0] barBase [NUM_BAR],
   output logic [NUM_BAR-1:0] hit
);
   // lowest bar wins if software programs overlapping windows;
   // a base of zero disables that bar
   always_comb begin
      hit = '0;
      for (int i = NUM_BAR - 1; i >= 0; i--) begin
         if (barBase[i] != 32'h0 &&
             addr[31:BAR_SIZE_BITS] == barBase[i][31:BAR_SIZE_BITS]) begin
            hit = '0;
            hit[i] = 1'b1;
         end
      end
   end
endmodule

// File: logic/pcitr_target_read.sv
// Function
// RL1: claim cycle: local frame and bar bit
// RL2: bar zero hit sets status bit 0
// RL3: claim cycle shows latched command and address
// RL4: enable control drivers one cycle before claiming
// RL5: status bit 7 flags 64-bit transfer
// RL6: status bit 8 flags pci side busy
// RL7: assert devseln and ack64n after claim cycle
// RL8: assert local accept in that cycle
// RL9: turn on ad drivers in that cycle
// RL10: transfer counts edge after ready and accept
// RL11: next edge registers local word onto ad
// RL12: trdyn asserted with first driven read data
// RL13: latch address, command; decode bars first
// RL14: local frame, accept, ready are active low
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
module pcitr_target_read import pcitr_pkg::*; #(
   parameter int DATA_W = 64,
   parameter int NUM_BAR = 6,
   parameter int BAR_SIZE_BITS = 12
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [DATA_W-1:0] pciAdIn,
   output logic [DATA_W-1:0] pciAdOut,
   output logic pciAdOe,
   input wire logic [3:0] pciCbeIn_n,
   input wire logic pciFrame_n,
   input wire logic pciIrdy_n,
   input wire logic pciReq64_n,
   output logic pciDevsel_n,
   output logic pciAck64_n,
   output logic pciTrdy_n,
   output logic pciStop_n,
   output logic pciTargetCtlOe,
   output logic localTargetFrame_n,
   output logic [pcitr_pkg::TSV_W-1:0] targetStatusVector,
   output logic [3:0] localCmdOut,
   output logic [31:0] localAddrOut,
   output logic localTargetAccept_n,
   input wire logic localTargetReady_n,
   input wire logic [DATA_W-1:0] localDataIn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import pcitr_pkg::*;

   pcitr_state_t state_q, state_d;
   logic framePrev_q;
   logic [31:0] addr_q;
   logic [3:0] cmd_q;
   logic wide_q;
   logic [NUM_BAR-1:0] hitVec;
   logic decodeOk, phaseDone, xfer_q, xfer_d, adLoad, acceptNext;
   logic ctrlEn_q;
   logic [31:0] barBase_q [NUM_BAR];
   logic [7:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic doWrite, wrMapped;
   logic [1:0] bufLevel;

   pcitr_stream_if #(.W(DATA_W)) toBuf ();
   pcitr_stream_if #(.W(DATA_W)) fromBuf ();

   pcitr_bar_decode #(.NUM_BAR(NUM_BAR), .BAR_SIZE_BITS(BAR_SIZE_BITS)) uDecode (
      .addr(addr_q),
      .barBase(barBase_q),
      .hit(hitVec)
   );

   // two words of slack let the local side run ahead while the master waits
   pcitr_pair_buf #(.W(DATA_W), .DEPTH(2)) uBuf (
      .clk(clk),
      .rst(rst),
      .flush(state_q == ST_DONE),
      .inS(toBuf.snk),
      .outS(fromBuf.src),
      .level(bufLevel)
   );

   // only memory reads are claimed, and only while software enables us
   assign decodeOk = ctrlEn_q && (|hitVec) &&
      (cmd_q == CMD_MEM_READ || cmd_q == CMD_READ_MULT || cmd_q == CMD_READ_LINE); // see RL13
   // a data phase ends on an edge that sees irdyn and our trdyn both low
   assign phaseDone = !pciIrdy_n && !pciTrdy_n;
   // both low-active strobes asserted now: word counts at the coming edge
   assign xfer_d = (state_q == ST_DATA) && !localTargetAccept_n && !localTargetReady_n; // see RL10 RL14
   assign toBuf.valid = xfer_q;
   assign toBuf.data = localDataIn;
   // ad register takes a word when the bus holds none or its phase completes
   assign adLoad = (state_q == ST_DATA) && fromBuf.valid && (pciTrdy_n || phaseDone);
   assign fromBuf.ready = adLoad;
   // counting words in flight keeps the buffer from ever overflowing
   assign acceptNext = (3'(bufLevel) + 3'(xfer_q) + 3'(xfer_d)) < 3'd2;

   // transaction sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (framePrev_q && !pciFrame_n) begin
               state_d = ST_DECODE;
            end
         end
         ST_DECODE: begin
            state_d = decodeOk ? ST_CLAIM : ST_IDLE;
         end
         ST_CLAIM: begin
            state_d = ST_DATA;
         end
         ST_DATA: begin
            if (phaseDone && pciFrame_n) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         framePrev_q <= 1'b1;
      end else begin
         state_q <= state_d;
         framePrev_q <= pciFrame_n;
      end
   end

   // address phase capture: the edge that first sees frame low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_q <= 32'h0;
         cmd_q <= 4'h0;
         wide_q <= 1'b0;
      end else if (state_q == ST_IDLE && framePrev_q && !pciFrame_n) begin
         addr_q <= pciAdIn[31:0]; // see RL13
         cmd_q <= pciCbeIn_n;
         wide_q <= !pciReq64_n;
      end
   end

   // local side claim, command and address
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         localTargetFrame_n <= 1'b1;
         localCmdOut <= 4'h0;
         localAddrOut <= 32'h0;
      end else if (state_d == ST_CLAIM) begin
         localTargetFrame_n <= 1'b0; // see RL1 RL14
         localCmdOut <= cmd_q; // see RL3
         localAddrOut <= addr_q;
      end else if (state_d == ST_DONE || state_d == ST_IDLE) begin
         localTargetFrame_n <= 1'b1;
      end
   end

   // status vector: bar hit, width, busy, burst seen, phase done
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         targetStatusVector <= '0;
      end else if (state_d == ST_CLAIM) begin
         targetStatusVector <= '0;
         targetStatusVector[NUM_BAR-1:0] <= hitVec; // see RL1 RL2
         targetStatusVector[TSV_WIDE] <= wide_q; // see RL5
         targetStatusVector[TSV_BUSY] <= 1'b1; // see RL6
      end else if (state_q == ST_DATA) begin
         if (!pciFrame_n && !pciIrdy_n) begin
            targetStatusVector[TSV_BURST] <= 1'b1;
         end
         if (state_d == ST_DONE) begin
            targetStatusVector[TSV_DONE] <= 1'b1;
         end
      end else if (state_q == ST_DONE) begin
         targetStatusVector <= '0;
      end
   end

   // control pins: drive high first, assert a cycle later, park high, release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pciTargetCtlOe <= 1'b0;
         pciDevsel_n <= 1'b1;
         pciAck64_n <= 1'b1;
         pciStop_n <= 1'b1;
      end else begin
         pciStop_n <= 1'b1; // disconnect is not issued by this block
         if (state_d == ST_CLAIM) begin
            pciTargetCtlOe <= 1'b1; // see RL4
         end else if (state_d == ST_IDLE) begin
            pciTargetCtlOe <= 1'b0;
         end
         if (state_d == ST_DATA && state_q == ST_CLAIM) begin
            pciDevsel_n <= 1'b0; // see RL7
            pciAck64_n <= !wide_q;
         end else if (state_d != ST_DATA) begin
            pciDevsel_n <= 1'b1;
            pciAck64_n <= 1'b1;
         end
      end
   end

   // local accept and the registered transfer strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         localTargetAccept_n <= 1'b1;
         xfer_q <= 1'b0;
      end else begin
         xfer_q <= xfer_d; // see RL10
         if (state_d == ST_DATA) begin
            localTargetAccept_n <= !acceptNext; // see RL8 RL14
         end else begin
            localTargetAccept_n <= 1'b1;
         end
      end
   end

   // ad drivers come on with devsel so the bus never floats waiting for data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pciAdOe <= 1'b0;
         pciAdOut <= '0;
         pciTrdy_n <= 1'b1;
      end else begin
         pciAdOe <= (state_d == ST_DATA); // see RL9
         if (adLoad) begin
            pciAdOut <= fromBuf.data; // see RL11
            pciTrdy_n <= 1'b0; // see RL12
         end else if (state_q != ST_DATA || phaseDone) begin
            pciTrdy_n <= 1'b1;
         end
      end
   end

   // axi4-lite write channels, taken in either order
   assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   always_comb begin
      wrMapped = (awAddr_q == OFF_CTRL) || (awAddr_q == OFF_STATUS);
      for (int i = 0; i < NUM_BAR; i++) begin
         if (awAddr_q == OFF_BAR0 + 8'(4 * i)) begin
            wrMapped = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         awAddr_q <= 8'h0;
         wData_q <= 32'h0;
         wStrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // software registers; status is read only, byte strobes honoured
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrlEn_q <= CTRL_EN_RST;
         for (int i = 0; i < NUM_BAR; i++) begin
            barBase_q[i] <= BAR_RST;
         end
      end else if (doWrite) begin
         if (awAddr_q == OFF_CTRL && wStrb_q[0]) begin
            ctrlEn_q <= wData_q[CTRL_EN_BIT];
         end
         for (int i = 0; i < NUM_BAR; i++) begin
            if (awAddr_q == OFF_BAR0 + 8'(4 * i)) begin
               for (int b = 0; b < 4; b++) begin
                  if (wStrb_q[b]) begin
                     barBase_q[i][8*b +: 8] <= wData_q[8*b +: 8];
                  end
               end
            end
         end
      end
   end

   // axi4-lite read: one cycle from address to data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_SLVERR;
         if (s_axi_araddr == OFF_CTRL) begin
            s_axi_rdata[CTRL_EN_BIT] <= ctrlEn_q;
            s_axi_rresp <= RESP_OKAY;
         end else if (s_axi_araddr == OFF_STATUS) begin
            s_axi_rdata <= {11'h0, state_q, cmd_q, targetStatusVector};
            s_axi_rresp <= RESP_OKAY;
         end
         for (int i = 0; i < NUM_BAR; i++) begin
            if (s_axi_araddr == OFF_BAR0 + 8'(4 * i)) begin
               s_axi_rdata <= barBase_q[i];
               s_axi_rresp <= RESP_OKAY;
            end
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// File: verification/pcitr_target_read_asserts.sv
module pcitr_target_read_asserts import pcitr_pkg::*; #(
   parameter int DATA_W = 64
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [DATA_W-1:0] pciAdIn,
   input wire logic [DATA_W-1:0] pciAdOut,
   input wire logic pciAdOe,
   input wire logic [3:0] pciCbeIn_n,
   input wire logic pciDevsel_n,
   input wire logic pciAck64_n,
   input wire logic pciTrdy_n,
   input wire logic pciTargetCtlOe,
   input wire logic localTargetFrame_n,
   input wire logic [pcitr_pkg::TSV_W-1:0] targetStatusVector,
   input wire logic [3:0] localCmdOut,
   input wire logic [31:0] localAddrOut,
   input wire logic localTargetAccept_n,
   input wire logic localTargetReady_n,
   input wire logic [DATA_W-1:0] localDataIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] adLo;
   // address half of the bus, so the latched copy compares at equal width
   assign adLo = pciAdIn[31:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // the claim cycle tells the local side first
   chk_claim_frame: assert property ($rose(pciTargetCtlOe) |->
      !localTargetFrame_n && targetStatusVector[TSV_BUSY]) else $error("claim without frame");
   chk_ctl_lead: assert property ($rose(pciTargetCtlOe) |=> !pciDevsel_n)
      else $error("devsel late after driver enable");
   // devsel must never be driven low from an undriven pin in the same cycle
   chk_devsel_oe: assert property (!pciDevsel_n |->
      pciTargetCtlOe && $past(pciTargetCtlOe)) else $error("devsel without prior enable");
   chk_accept_ad: assert property ($fell(pciDevsel_n) |->
      !localTargetAccept_n && pciAdOe) else $error("accept or ad drivers missing at claim");
   chk_ack_wide: assert property ($fell(pciDevsel_n) |->
      pciAck64_n == !targetStatusVector[TSV_WIDE]) else $error("ack64 disagrees with width");
   chk_xfer_trdy: assert property ($fell(pciTrdy_n) |->
      $past(localTargetAccept_n, 2) == 1'b0 && $past(localTargetReady_n, 2) == 1'b0)
      else $error("trdy not two edges after local transfer");
   chk_ad_word: assert property ($fell(pciTrdy_n) |->
      pciAdOe && pciAdOut == $past(localDataIn)) else $error("ad word not the local word");
   chk_claim_addr: assert property ($fell(localTargetFrame_n) |->
      localCmdOut == $past(pciCbeIn_n, 2) && localAddrOut == $past(adLo, 2))
      else $error("claim shows wrong command or address");
   cover property ($fell(pciAck64_n));
   cover property ($fell(pciTrdy_n) && !targetStatusVector[TSV_WIDE]);
   cover property ($fell(localTargetFrame_n) && targetStatusVector[1]);
endmodule

bind pcitr_target_read pcitr_target_read_asserts #(.DATA_W(DATA_W)) pcitr_target_read_asserts_i (
   .clk, .rst, .pciAdIn, .pciAdOut, .pciAdOe, .pciCbeIn_n, .pciDevsel_n, .pciAck64_n,
   .pciTrdy_n, .pciTargetCtlOe, .localTargetFrame_n, .targetStatusVector, .localCmdOut,
   .localAddrOut, .localTargetAccept_n, .localTargetReady_n, .localDataIn);

// File: verification/pcitr_local_model.sv
module pcitr_local_model #(
   parameter int DATA_W = 64
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic localTargetFrame_n,
   input wire logic localTargetAccept_n,
   input wire logic [3:0] delay,
   input wire logic [DATA_W-1:0] word,
   output logic localTargetReady_n,
   output logic [DATA_W-1:0] localDataIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_q;
   logic served_q;
   logic held_q;
   // one word per claim; data is only valid up to the edge after the transfer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         localTargetReady_n <= 1'b1;
         wait_q <= 4'h0;
         served_q <= 1'b0;
         held_q <= 1'b0;
         localDataIn <= '0;
      end else begin
         held_q <= 1'b0;
         if (held_q || localTargetFrame_n) begin
            localDataIn <= ~word; // stale data shows inverted, never the old word
         end
         if (localTargetFrame_n) begin
            served_q <= 1'b0;
            wait_q <= 4'h0;
         end else if (!localTargetReady_n && !localTargetAccept_n) begin
            localTargetReady_n <= 1'b1;
            served_q <= 1'b1;
            held_q <= 1'b1;
         end else if (localTargetReady_n && !served_q && !localTargetAccept_n) begin
            if (wait_q == delay) begin
               localTargetReady_n <= 1'b0;
               localDataIn <= word;
            end else begin
               wait_q <= wait_q + 4'h1; // slow local side stalls here
            end
         end
      end
   end
endmodule

// File: verification/testbench.sv
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("FAIL %0t mismatch", $time); end end

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pcitr_pkg::*;
   logic clk, rst, pciAdOe, pciFrame_n, pciIrdy_n, pciReq64_n, pciDevsel_n, pciAck64_n;
   logic pciTrdy_n, pciTargetCtlOe, localTargetFrame_n, localTargetAccept_n, localTargetReady_n;
   logic [63:0] pciAdIn, pciAdOut, localDataIn, word;
   logic [3:0] pciCbeIn_n, localCmdOut, delay, s_axi_wstrb;
   logic [11:0] targetStatusVector;
   logic [31:0] localAddrOut, s_axi_wdata, s_axi_rdata;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pciStop_n;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int failures, n_compared;

   pcitr_target_read pcitr_target_read_i (.clk, .rst, .pciAdIn, .pciAdOut, .pciAdOe,
      .pciCbeIn_n, .pciFrame_n, .pciIrdy_n, .pciReq64_n, .pciDevsel_n, .pciAck64_n, .pciTrdy_n,
      .pciStop_n, .pciTargetCtlOe, .localTargetFrame_n, .targetStatusVector, .localCmdOut,
      .localAddrOut, .localTargetAccept_n, .localTargetReady_n, .localDataIn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   pcitr_local_model pcitr_local_model_i (.clk, .rst, .localTargetFrame_n,
      .localTargetAccept_n, .delay, .word, .localTargetReady_n, .localDataIn);

   task automatic close_out();
      if (failures == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // address and data are offered together and dropped as each is taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, er)
      @(posedge clk); // a following call must not raise bready in the step that dropped it
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      `CHK(s_axi_rdata, ed)
      `CHK(s_axi_rresp, er)
      @(posedge clk); // one idle edge between reads keeps rready single-driven per step
   endtask

   // single-phase read: master drops frame and raises irdy right after the address
   task automatic pci_rd(input logic [31:0] a, input logic [3:0] c, input logic wide,
                         input logic [11:0] etsv, input logic [63:0] d);
      logic claimed;
      int i;
      claimed = 1'b0;
      word <= d;
      @(posedge clk);
      pciFrame_n <= 1'b0;
      pciAdIn <= {32'h0, a};
      pciCbeIn_n <= c;
      pciReq64_n <= !wide;
      @(posedge clk);
      pciFrame_n <= 1'b1;
      pciIrdy_n <= 1'b0;
      pciReq64_n <= 1'b1;
      pciAdIn <= ~{32'h0, a}; // released ad no longer shows the address
      pciCbeIn_n <= ~c;
      for (i = 0; i < 20 && pciTrdy_n !== 1'b0; i++) begin
         @(posedge clk);
         if (localTargetFrame_n === 1'b0 && !claimed) begin
            claimed = 1'b1;
            `CHK(targetStatusVector, etsv)
            `CHK(localCmdOut, c)
            `CHK(localAddrOut, a)
            `CHK(pciTargetCtlOe, 1'b1)
            `CHK(pciStop_n, 1'b1)
         end
      end
      `CHK(claimed, etsv != 12'h0)
      if (claimed) `CHK(pciAdOut, d)
      pciIrdy_n <= 1'b1;
      // the edge that ends the phase leaves busy up and marks the phase done
      @(posedge clk);
      `CHK(targetStatusVector, claimed ? (etsv | (12'h1 << TSV_DONE)) : 12'h0)
      repeat (2) @(posedge clk);
      `CHK(targetStatusVector, 12'h0)
      `CHK(pciTargetCtlOe, 1'b0)
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // generous bound: the whole sequence needs under two hundred cycles
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      close_out();
   end

   initial begin
      failures = 0;
      n_compared = 0;
      rst = 1'b1;
      {pciFrame_n, pciIrdy_n, pciReq64_n} = 3'h7;
      pciAdIn = '0;
      pciCbeIn_n = 4'h0;
      word = '0;
      delay = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      axi_rd(OFF_CTRL, 32'h0, RESP_OKAY);
      axi_rd(OFF_BAR0, BAR_RST, RESP_OKAY);
      axi_rd(OFF_STATUS, 32'h0001_0000, RESP_OKAY);
      axi_rd(8'h08, 32'h0, RESP_SLVERR);
      axi_wr(8'h08, 32'h1, RESP_SLVERR);
      axi_wr(OFF_BAR0, 32'h0001_0000, RESP_OKAY);
      axi_wr(OFF_BAR0 + 8'h04, 32'h0002_0000, RESP_OKAY);
      pci_rd(32'h0001_0040, CMD_MEM_READ, 1'b1, 12'h0, 64'h0);
      axi_wr(OFF_CTRL, 32'h1, RESP_OKAY);
      axi_rd(OFF_CTRL, 32'h1, RESP_OKAY);
      pci_rd(32'h0001_0040, CMD_MEM_READ, 1'b1, 12'h181, 64'h0123_4567_89ab_cdef);
      delay <= 4'h3;
      pci_rd(32'h0002_0080, CMD_READ_MULT, 1'b0, 12'h102, 64'hfedc_ba98_7654_3210);
      pci_rd(32'h0002_00c0, CMD_READ_LINE, 1'b0, 12'h102, 64'h5a5a_0f0f_a5a5_f0f0);
      pci_rd(32'h0003_0000, CMD_MEM_READ, 1'b0, 12'h0, 64'h0);
      pci_rd(32'h0001_0000, 4'h7, 1'b0, 12'h0, 64'h0);
      close_out();
   end
endmodule
